// [logic/clock_controller_defs.svh]
`ifndef CLOCK_CONTROLLER_DEFS_SVH
`define CLOCK_CONTROLLER_DEFS_SVH

// ******************************
// Register indices (byte address is four times the index)
// ******************************
`define IDX_CTRL_A 6'h00
`define IDX_PRESCALE 6'h01
`define IDX_LOCK 6'h02
`define IDX_STATUS 6'h03
`define IDX_FAST_CTRL 6'h10
`define IDX_CAL_A 6'h11
`define IDX_CAL_B 6'h12
`define IDX_SLOW_CTRL 6'h18
`define IDX_XTAL_CTRL 6'h1C
`define IDX_PROTECT 6'h20

// ******************************
// Reset values, key and timing
// ******************************
`define CTRL_A_RESET 3'b000
`define PRESCALE_RESET 5'b1_0001
`define UNLOCK_KEY 8'hD8
`define UNLOCK_ACCESSES 3'h4
`define SRC_FAST 2'h0
`define SRC_SLOW 2'h1
`define SRC_XTAL 2'h2
`define SRC_EXT 2'h3
`endif

// [logic/clock_controller_pkg.sv]
package clock_controller_pkg;
    typedef enum logic [1:0] {SW_RUN = 2'b00, SW_WAIT = 2'b01} switch_state_t;
    typedef struct packed {
        logic clk_out_en;
        logic [1:0] source;
    } main_ctrl_t;
    typedef struct packed {
        logic [3:0] divide;
        logic enable;
    } prescale_t;
    typedef struct packed {
        logic [1:0] startup;
        logic sel;
        logic run_standby;
        logic enable;
    } xtal_ctrl_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_t;
endpackage

// [logic/main_clock_unit.sv]
`timescale 1ns/1ns
`include "clock_controller_defs.svh"
module main_clock_unit
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Wishbone slave
    input clock_controller_pkg::wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator pins: 0 fast RC, 1 low-power RC, 2 crystal, 3 external
    input wire logic [3:0] source_tick_i,
    input wire logic [3:0] source_stable_i,
    output logic [3:0] source_run_o,
    // Calibration fuses, caught during reset
    input wire logic [5:0] cal_a_fuse_i,
    input wire logic [3:0] cal_b_fuse_i,
    input wire logic cal_fuse_lock_i,
    // System side
    input wire logic [3:0] peripheral_request_i,
    input wire logic sleep_i,
    input wire logic sysclk_in_use_i,
    output logic main_clock_en_o,
    output logic periph_clock_en_o,
    output logic clock_out_o
);
    import clock_controller_pkg::*;

    // ******************************
    // Declarations
    // ******************************
    logic [3:0] tick_sync_a;
    logic [3:0] tick_sync_b;
    logic [3:0] tick_prev;
    logic [3:0] stable_sync_a;
    logic [3:0] stable_sync;
    logic [3:0] tick_rise;
    main_ctrl_t ctrl_a;
    prescale_t prescale;
    logic locked;
    logic fast_run_standby;
    logic slow_run_standby;
    logic [5:0] cal_a;
    logic [3:0] cal_b;
    logic cal_fuse_lock;
    xtal_ctrl_t xtal;
    logic [2:0] window;
    logic ack_q;
    logic [1:0] active;
    switch_state_t state;
    switch_state_t next_state;
    logic [6:0] div_count;
    logic periph_level;

    function automatic logic [6:0] divide_m1(input logic [3:0] code);
        case (code)
            4'h0: divide_m1 = 7'h01;
            4'h1: divide_m1 = 7'h03;
            4'h2: divide_m1 = 7'h07;
            4'h3: divide_m1 = 7'h0F;
            4'h4: divide_m1 = 7'h1F;
            4'h5: divide_m1 = 7'h3F;
            4'h8: divide_m1 = 7'h05;
            4'h9: divide_m1 = 7'h09;
            4'hA: divide_m1 = 7'h0B;
            4'hB: divide_m1 = 7'h17;
            4'hC: divide_m1 = 7'h2F;
            // Reserved codes fall back to divide by two
            default: divide_m1 = 7'h01;
        endcase
    endfunction

    // ******************************
    // Pin synchronisers
    // ******************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge clock_i)
            begin
                tick_sync_a[gi] <= source_tick_i[gi];
                tick_sync_b[gi] <= tick_sync_a[gi];
                tick_prev[gi] <= tick_sync_b[gi];
                stable_sync_a[gi] <= source_stable_i[gi];
                stable_sync[gi] <= stable_sync_a[gi];
            end
        end
    endgenerate
    assign tick_rise = tick_sync_b & ~tick_prev;

    // ******************************
    // Bus decode
    // ******************************
    wire [5:0] index = wb_req_i.adr[7:2];
    wire [7:0] wdata = wb_req_i.dat[7:0];
    wire bus_req = wb_req_i.cyc & wb_req_i.stb;
    wire wr_fire = ack_q & bus_req & wb_req_i.we & wb_req_i.sel[0];
    wire unlocked = (window != 3'h0);
    wire prot_wr = wr_fire & unlocked;
    wire key_wr = wr_fire & (index == `IDX_PROTECT) & (wdata == `UNLOCK_KEY);
    wire main_wr_ok = prot_wr & ~locked;
    wire wr_ctrl_a = main_wr_ok & (index == `IDX_CTRL_A);
    wire wr_prescale = main_wr_ok & (index == `IDX_PRESCALE);
    wire wr_lock = main_wr_ok & (index == `IDX_LOCK);
    wire cal_locked = cal_fuse_lock | (locked & (active == `SRC_FAST));
    wire wr_cal_a = prot_wr & ~cal_locked & (index == `IDX_CAL_A);
    wire wr_cal_b = prot_wr & ~cal_locked & (index == `IDX_CAL_B);
    wire wr_fast = prot_wr & (index == `IDX_FAST_CTRL);
    wire wr_slow = prot_wr & (index == `IDX_SLOW_CTRL);
    wire wr_xtal = prot_wr & (index == `IDX_XTAL_CTRL);

    // ******************************
    // Source request and status
    // ******************************
    wire pending = (state == SW_WAIT);
    wire [3:0] active_hot = 4'h1 << active;
    wire [3:0] target_hot = 4'h1 << ctrl_a.source;
    wire [3:0] used = peripheral_request_i | active_hot | (pending ? target_hot : 4'h0);
    wire [3:0] requested = {used[3], used[2] & xtal.enable, used[1:0]};
    wire [3:0] src_status = stable_sync & requested;
    wire [7:0] status = {src_status[3], src_status[2], src_status[1], src_status[0],
                         3'b000, pending};
    wire xtal_frozen = xtal.enable | src_status[2];
    assign source_run_o = requested |
        {1'b0, xtal.run_standby & xtal.enable, slow_run_standby, fast_run_standby};

    // ******************************
    // Read mux
    // ******************************
    logic [7:0] read_value;
    always_comb
    begin
        read_value = 8'h00;
        case (index)
            `IDX_CTRL_A: read_value = {ctrl_a.clk_out_en, 5'b0_0000, ctrl_a.source};
            `IDX_PRESCALE: read_value = {3'b000, prescale.divide, prescale.enable};
            // The lock register always answers zero, locked or not
            `IDX_LOCK: read_value = 8'h00;
            `IDX_STATUS: read_value = status;
            `IDX_FAST_CTRL: read_value = {6'b00_0000, fast_run_standby, 1'b0};
            `IDX_CAL_A: read_value = {2'b00, cal_a};
            `IDX_CAL_B: read_value = {cal_fuse_lock, 3'b000, cal_b};
            `IDX_SLOW_CTRL: read_value = {6'b00_0000, slow_run_standby, 1'b0};
            `IDX_XTAL_CTRL: read_value = {2'b00, xtal.startup, 1'b0, xtal.sel,
                                          xtal.run_standby, xtal.enable};
            default: read_value = 8'h00;
        endcase
    end

    // ******************************
    // Bus slave
    // ******************************
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q)
                wb_dat_o <= {24'h00_0000, read_value};
        end
    end
    assign wb_ack_o = ack_q;

    // Window counts completed bus accesses after the key
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            window <= 3'h0;
        else if (key_wr)
            window <= `UNLOCK_ACCESSES;
        else if (ack_q & unlocked)
            window <= window - 3'h1;
    end

    // ******************************
    // Registers
    // ******************************
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ctrl_a <= `CTRL_A_RESET;
            prescale <= `PRESCALE_RESET;
            locked <= 1'b0;
            fast_run_standby <= 1'b0;
            slow_run_standby <= 1'b0;
            xtal <= '0;
            cal_a <= cal_a_fuse_i;
            cal_b <= cal_b_fuse_i;
            cal_fuse_lock <= cal_fuse_lock_i;
        end
        else
        begin
            if (wr_ctrl_a)
                ctrl_a <= {wdata[7], wdata[1:0]};
            if (wr_prescale)
                prescale <= wdata[4:0];
            if (wr_lock & wdata[0])
                locked <= 1'b1;
            if (wr_fast)
                fast_run_standby <= wdata[1];
            if (wr_slow)
                slow_run_standby <= wdata[1];
            if (wr_cal_a)
                cal_a <= wdata[5:0];
            if (wr_cal_b)
                cal_b <= wdata[3:0];
            if (wr_xtal)
            begin
                xtal.run_standby <= wdata[1];
                xtal.enable <= wdata[0];
                // Mode and start-up fields move only with the crystal idle
                if (!xtal_frozen)
                begin
                    xtal.startup <= wdata[5:4];
                    xtal.sel <= wdata[2];
                end
            end
        end
    end

    // ******************************
    // Source switch
    // ******************************
    always_comb
    begin
        next_state = state;
        case (state)
            SW_RUN: if (ctrl_a.source != active) next_state = SW_WAIT;
            SW_WAIT: if (stable_sync[ctrl_a.source]) next_state = SW_RUN;
            default: next_state = SW_RUN;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state <= SW_RUN;
            active <= `SRC_FAST;
        end
        else
        begin
            state <= next_state;
            if (state == SW_WAIT && stable_sync[ctrl_a.source])
                active <= ctrl_a.source;
        end
    end

    // ******************************
    // Prescaler and clock output
    // ******************************
    wire main_tick = tick_rise[active];
    wire [6:0] ratio_m1 = divide_m1(prescale.divide);
    wire div_wrap = (div_count >= ratio_m1);
    wire periph_tick = prescale.enable ? (main_tick & div_wrap) : main_tick;
    wire out_allowed = ctrl_a.clk_out_en & (~sleep_i | sysclk_in_use_i);

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            div_count <= 7'h00;
            periph_level <= 1'b0;
            main_clock_en_o <= 1'b0;
            periph_clock_en_o <= 1'b0;
            clock_out_o <= 1'b0;
        end
        else
        begin
            // Held at zero in bypass so the first divided period is a full one
            if (main_tick)
                div_count <= (div_wrap | ~prescale.enable) ? 7'h00 : div_count + 7'h01;
            if (periph_tick)
                periph_level <= ~periph_level;
            main_clock_en_o <= main_tick;
            periph_clock_en_o <= periph_tick;
            clock_out_o <= out_allowed & periph_level;
        end
    end

    // Main ticks since the last peripheral tick, kept apart from the divider
    logic [6:0] since_tick;
    always_ff @(posedge clock_i)
    begin
        if (rst_i | periph_tick)
            since_tick <= 7'h00;
        else if (main_tick)
            since_tick <= since_tick + 7'h01;
    end

    // ******************************
    // Assertions
    // ******************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    AST_KEY_OPENS: assert property (key_wr |=> window == `UNLOCK_ACCESSES)
        else $error("unlock key did not open the window");
    AST_NO_KEY_KEEPS: assert property (wr_fire && !unlocked && index == `IDX_PRESCALE
        |=> $stable(prescale))
        else $error("prescale changed without unlock");
    AST_CAL_PROTECTED: assert property (wr_fire && !unlocked && index == `IDX_CAL_A
        |=> $stable(cal_a))
        else $error("calibration changed without unlock");
    AST_SYSTEM_CLOCK_OUTPUT_ENABLE_OFF: assert property (!ctrl_a.clk_out_en |=> !clock_out_o)
        else $error("clock pin active while disabled");
    AST_SLEEP_QUIET: assert property (sleep_i && !sysclk_in_use_i |=> !clock_out_o)
        else $error("clock pin active in sleep");
    AST_BYPASS: assert property (!prescale.enable && main_tick |=> periph_clock_en_o)
        else $error("undivided clock missing");
    AST_DIV_GAP: assert property (prescale.enable && main_tick && since_tick < ratio_m1
        |-> !periph_tick)
        else $error("peripheral tick before ratio reached");
    AST_LOCK_FREEZE: assert property (locked && wr_fire && index == `IDX_CTRL_A
        |=> $stable(ctrl_a))
        else $error("control A changed while locked");
    AST_LOCK_STICKY: assert property (locked |=> locked)
        else $error("lock cleared without reset");
    AST_STATUS_GATE: assert property (!requested[2] |-> !status[6])
        else $error("crystal status shown while unrequested");
    AST_SWITCH_WAIT: assert property (pending && !stable_sync[ctrl_a.source]
        |=> active == $past(active) && status[0])
        else $error("main clock switched before source stable");
    AST_RESET_STATE: assert property ($past(rst_i) |-> prescale == `PRESCALE_RESET
        && active == `SRC_FAST)
        else $error("wrong state after reset");

    COV_UNLOCK_WRITE: cover property (key_wr ##[1:8] wr_prescale);
    COV_SWITCH: cover property (pending ##[1:20] !pending);
    COV_LOCK: cover property (wr_lock && wdata[0]);
    COV_DIVIDED: cover property (prescale.enable && periph_tick);
endmodule

// [verification/main_clock_select_prescale_lock_bench.sv]
`timescale 1ns/1ns
module main_clock_select_prescale_lock_bench;
    import clock_controller_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_t wb_req_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] source_tick_i = 4'h0;
    logic [3:0] source_stable_i = 4'hF;
    logic [3:0] source_run_o;
    logic [5:0] cal_a_fuse_i = 6'h00;
    logic [3:0] cal_b_fuse_i = 4'h0;
    logic cal_fuse_lock_i = 1'b0;
    logic [3:0] peripheral_request_i = 4'h0;
    logic sleep_i = 1'b0;
    logic sysclk_in_use_i = 1'b0;
    logic main_clock_en_o;
    logic periph_clock_en_o;
    logic clock_out_o;
    logic [31:0] seed = 32'h0000_ec85;
    logic [7:0] tick_cnt = 8'h00;
    logic [7:0] ex [0:31];
    logic [7:0] mk [0:31];
    logic [7:0] prot [8] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'h18, 8'h1C};
    int code [11] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12};
    int ratio [11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    logic locked;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    logic [7:0] q;
    int t;

    main_clock_unit DUT (.clock_i(clock_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_tick_i(source_tick_i),
        .source_stable_i(source_stable_i), .source_run_o(source_run_o),
        .cal_a_fuse_i(cal_a_fuse_i), .cal_b_fuse_i(cal_b_fuse_i),
        .cal_fuse_lock_i(cal_fuse_lock_i), .peripheral_request_i(peripheral_request_i),
        .sleep_i(sleep_i), .sysclk_in_use_i(sysclk_in_use_i),
        .main_clock_en_o(main_clock_en_o), .periph_clock_en_o(periph_clock_en_o),
        .clock_out_o(clock_out_o));

    always #5 clock_i = ~clock_i;

    // ******************************
    // Oscillator ticks: fast RC every 4 cycles, low-power RC every 8
    // ******************************
    always @(posedge clock_i)
    begin
        tick_cnt <= tick_cnt + 8'h01;
        source_tick_i <= {tick_cnt[1], tick_cnt[3], tick_cnt[2], tick_cnt[1]};
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic end_sim();
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // ******************************
    // Bus access and register model
    // ******************************
    task automatic bus(input logic we, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] rd_q);
        @(posedge clock_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {i[5:0], 2'b00},
            dat: {24'h00_0000, d}};
        do
            @(posedge clock_i);
        while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o[7:0];
        wb_req_i <= '0;
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] want);
        logic [7:0] v;
        bus(1'b0, i, 8'h00, v);
        chk(v, want);
    endtask

    task automatic pw(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] v;
        bus(1'b1, 8'h20, 8'hD8, v);
        bus(1'b1, i, d, v);
        if (!(locked && (i < 8'h03 || i == 8'h11 || i == 8'h12)))
            ex[i] = (ex[i] & ~mk[i]) | (d & mk[i]);
        if (i == 8'h02 && d[0])
            locked = 1'b1;
        if (i == 8'h1C)
            mk[28] = ex[28][0] ? 8'h03 : 8'h37;
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        ex = '{default: 8'h00};
        mk = '{default: 8'h00};
        ex[1] = 8'h11;
        ex[17] = {2'b00, cal_a_fuse_i};
        ex[18] = {cal_fuse_lock_i, 3'b000, cal_b_fuse_i};
        mk[0] = 8'h83;
        mk[1] = 8'h1F;
        mk[16] = 8'h02;
        mk[17] = 8'h3F;
        mk[18] = 8'h0F;
        mk[24] = 8'h02;
        mk[28] = 8'h37;
        locked = 1'b0;
    endtask

    task automatic check_all();
        foreach (prot[k])
            rd(prot[k], ex[prot[k]]);
    endtask

    // Cycles between pulses, taken on the third interval so a ratio change has settled
    task automatic period(input logic per, input int want);
        int n;
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(posedge clock_i);
                n++;
            end
            while ((per ? periph_clock_en_o : main_clock_en_o) !== 1'b1 && n < 2000);
        end
        chk(n, want);
    endtask

    task automatic toggles(output int n);
        logic last;
        n = 0;
        // Let a setting written at the last edge reach the pin first
        repeat (2) @(posedge clock_i);
        last = clock_out_o;
        repeat (64)
        begin
            @(posedge clock_i);
            if (clock_out_o !== last)
                n++;
            last = clock_out_o;
        end
    endtask

    // ******************************
    // Main sequence
    // ******************************
    initial
    begin
        {cal_a_fuse_i, cal_b_fuse_i} <= 10'(xs());
        do_reset();
        repeat (4) @(posedge clock_i);
        check_all();
        rd(8'h03, 8'h10);
        rd(8'h05, 8'h00);
        period(1'b0, 4);
        period(1'b1, 24);
        foreach (prot[k])
        begin
            bus(1'b1, prot[k], 8'(xs()), q);
            rd(prot[k], ex[prot[k]]);
        end
        foreach (prot[k])
            if (prot[k] != 8'h02)
                pw(prot[k], 8'(prot[k] == 8'h00 ? xs() & 32'h80 : xs() | (prot[k] == 8'h1C)));
        check_all();
        pw(8'h1C, ~ex[28]);
        rd(8'h1C, ex[28]);
        bus(1'b1, 8'h20, 8'hD8, q);
        repeat (3) rd(8'h05, 8'h00);
        bus(1'b1, 8'h01, 8'h03, q);
        rd(8'h01, 8'h03);
        bus(1'b1, 8'h20, 8'hD8, q);
        repeat (4) rd(8'h05, 8'h00);
        bus(1'b1, 8'h01, 8'h05, q);
        rd(8'h01, 8'h03);
        ex[1] = 8'h03;
        foreach (code[k])
        begin
            pw(8'h01, {3'b000, code[k][3:0], 1'b1});
            period(1'b1, ratio[k] * 4);
        end
        pw(8'h01, 8'h0A);
        period(1'b1, 4);
        pw(8'h01, 8'h1F);
        rd(8'h01, 8'h1F);
        pw(8'h00, 8'h00);
        toggles(t);
        chk(t, 0);
        pw(8'h00, 8'h80);
        toggles(t);
        chk(t > 0, 1);
        sleep_i <= 1'b1;
        toggles(t);
        chk(t, 0);
        sysclk_in_use_i <= 1'b1;
        toggles(t);
        chk(t > 0, 1);
        sleep_i <= 1'b0;
        sysclk_in_use_i <= 1'b0;
        peripheral_request_i <= 4'hE;
        repeat (6) @(posedge clock_i);
        rd(8'h03, {1'b1, ex[28][0], 6'b11_0000});
        peripheral_request_i <= 4'h0;
        source_stable_i <= 4'h0;
        repeat (6) @(posedge clock_i);
        rd(8'h03, 8'h00);
        source_stable_i <= 4'hD;
        pw(8'h00, 8'h01);
        bus(1'b0, 8'h03, 8'h00, q);
        chk(q[0], 1'b1);
        period(1'b0, 4);
        source_stable_i <= 4'hF;
        repeat (8) @(posedge clock_i);
        bus(1'b0, 8'h03, 8'h00, q);
        chk(q[0], 1'b0);
        period(1'b0, 8);
        pw(8'h00, 8'h00);
        repeat (12) @(posedge clock_i);
        pw(8'h02, 8'h01);
        pw(8'h01, 8'h07);
        pw(8'h00, 8'h81);
        pw(8'h11, 8'(xs()));
        pw(8'h02, 8'h00);
        pw(8'h01, 8'h09);
        check_all();
        do_reset();
        check_all();
        pw(8'h01, 8'h03);
        rd(8'h01, 8'h03);
        end_sim();
    end
endmodule
